// *** hw/bcsp_pkg.sv ***
// Constants and decode helpers for the bus control shared port.
package bcsp_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned BCSP_ADDR_W = 20;
    localparam int unsigned BCSP_DATA_W = 32;
    localparam int unsigned BCSP_PINS = 8;

    // ************************************************************
    // Register indices and byte addresses
    // ************************************************************
    // The printed offsets are not word aligned, so each is an index
    // and the byte address is four times the index.
    localparam logic [15:0] BCSP_IDX_DIRECTION = 16'hfebe;
    localparam logic [15:0] BCSP_IDX_PIN_LEVELS = 16'hff5e;
    localparam logic [15:0] BCSP_IDX_OUTPUT_LATCH = 16'hff6e;
    localparam logic [19:0] BCSP_ADDR_DIRECTION = {2'b00, BCSP_IDX_DIRECTION, 2'b00};
    localparam logic [19:0] BCSP_ADDR_PIN_LEVELS = {2'b00, BCSP_IDX_PIN_LEVELS, 2'b00};
    localparam logic [19:0] BCSP_ADDR_OUTPUT_LATCH = {2'b00, BCSP_IDX_OUTPUT_LATCH, 2'b00};

    // ************************************************************
    // Values after reset and fixed read values
    // ************************************************************
    localparam logic [7:0] BCSP_DIR_RST_EXT = 8'h80;
    localparam logic [7:0] BCSP_DIR_RST_SINGLE = 8'h00;
    localparam logic [7:0] BCSP_LATCH_RST = 8'h00;
    localparam logic [7:0] BCSP_DIR_READ_VALUE = 8'h00;
    localparam logic [31:0] BCSP_UNMAPPED_READ = 32'h0000_0000;

    // ************************************************************
    // Pin positions
    // ************************************************************
    localparam int unsigned BCSP_PIN_CLOCK = 7;
    localparam int unsigned BCSP_PIN_ADDR_STROBE = 6;
    localparam int unsigned BCSP_PIN_LWR = 3;
    localparam int unsigned BCSP_PIN_WAIT = 2;
    localparam int unsigned BCSP_PIN_BUS_ACK = 1;
    localparam int unsigned BCSP_PIN_BUS_REQ = 0;

    // ************************************************************
    // Operating modes
    // ************************************************************
    localparam logic [2:0] BCSP_MODE_1 = 3'h1;
    localparam logic [2:0] BCSP_MODE_2 = 3'h2;
    localparam logic [2:0] BCSP_MODE_4 = 3'h4;
    localparam logic [2:0] BCSP_MODE_5 = 3'h5;
    localparam logic [2:0] BCSP_MODE_6 = 3'h6;

    // Modes outside the external-bus group, mode 0 included, act as single-chip.
    function automatic logic bcsp_is_ext_mode(input logic [2:0] mode);
        bcsp_is_ext_mode = (mode == BCSP_MODE_1) || (mode == BCSP_MODE_2) ||
                           (mode == BCSP_MODE_4) || (mode == BCSP_MODE_5) ||
                           (mode == BCSP_MODE_6);
    endfunction

endpackage

// *** hw/bcsp_pin_mux.sv ***
// Pin function multiplexer of the bus control shared port.
`timescale 1ns/1ns
module bcsp_pin_mux (
    input wire logic ext_mode,
    input wire logic [7:0] direction,
    input wire logic [7:0] latch,
    input wire logic sys_clock_level,
    input wire logic [3:0] strobes_n,
    input wire logic bus_ack_n,
    input wire logic stall_en,
    input wire logic release_en,
    input wire logic standby,
    input wire logic hold,
    output logic [7:0] next_out,
    output logic [7:0] next_oe
);

    logic bus_drive;

    // A bus control output is released in standby unless hold is set.
    assign bus_drive = !standby || hold;

    always_comb begin
        // RQ8: general I/O default
        next_out = latch;
        next_oe = direction;
        // RQ5: clock output pin
        next_out[bcsp_pkg::BCSP_PIN_CLOCK] = sys_clock_level;
        if (ext_mode) begin
            // RQ6: strobes ignore direction
            next_out[bcsp_pkg::BCSP_PIN_ADDR_STROBE:bcsp_pkg::BCSP_PIN_LWR] = strobes_n;
            // RQ4: standby hold or release
            next_oe[bcsp_pkg::BCSP_PIN_ADDR_STROBE:bcsp_pkg::BCSP_PIN_LWR] = {4{bus_drive}};
            // RQ12: wait input takeover
            if (stall_en) begin
                next_oe[bcsp_pkg::BCSP_PIN_WAIT] = 1'b0;
            end
            // RQ13: bus release pins
            if (release_en) begin
                next_out[bcsp_pkg::BCSP_PIN_BUS_ACK] = bus_ack_n;
                next_oe[bcsp_pkg::BCSP_PIN_BUS_ACK] = bus_drive;
                next_oe[bcsp_pkg::BCSP_PIN_BUS_REQ] = 1'b0;
            end
        end
    end

endmodule

// *** hw/bcsp_port.sv ***
// Bus control shared port: APB registers, pin sampling and pin drive.
//
// Notes on behaviour
// RQ1: The direction register is an 8-bit write-only register, one bit per pin, 1 for output.
// RQ2: Reset and hardware standby load direction with 80h in modes 1,2,4,5,6 and 00h in 3,7.
// RQ3: Direction, output latch and pin-state view keep their contents in software standby.
// RQ4: In software standby the bus control outputs hold their level or float, by the hold bit.
// RQ5: Pin 7 drives the system clock when its direction bit is 1, else it is an input.
// RQ6: In external-bus modes pins 6 to 3 drive the four bus strobes, except in software standby without hold (RQ4).
// RQ7: In external-bus modes pins 2 to 0 carry wait, acknowledge and request when enabled.
// RQ8: In single-chip modes pins 6 to 0 are plain outputs or inputs by their direction bits.
// RQ9: The output latch is readable and writable and clears to 00h on reset or hw standby.
// RQ10: Software sets pin levels only through the output latch; the pin view is read-only.
// RQ11: Each pin view bit reads the latch bit when output and the live pin when input.
// RQ12: In external-bus modes pin 2 is the wait input while the stall enable is set.
// RQ13: In external-bus modes the release enable makes pin 1 acknowledge and pin 0 request.
// RQ14: The static mode input is decoded into an external-bus group and a single-chip group.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module bcsp_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [2:0] op_mode,
    input wire logic hw_standby,
    input wire logic soft_standby,
    input wire logic standby_output_hold,
    input wire logic stall_input_enable,
    input wire logic bus_release_enable,
    input wire logic sys_clock_level,
    input wire logic address_strobe_n,
    input wire logic read_strobe_n,
    input wire logic upper_byte_write_n,
    input wire logic lower_byte_write_n,
    input wire logic bus_ack_n,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic wait_n,
    output logic bus_request_n
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic ext_mode;
    logic [7:0] port_direction;
    logic [7:0] port_output_latch;
    logic [7:0] port_pin_levels;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic standby_meta;
    logic standby_sync;
    logic init_pending;
    logic [3:0] held_strobes_n;
    logic held_bus_ack_n;
    logic [3:0] live_strobes_n;
    logic [3:0] mux_strobes_n;
    logic mux_bus_ack_n;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_direction;
    logic access;
    logic wr_dir;
    logic wr_latch;
    logic hit;

    // RQ14: mode group decode
    assign ext_mode = bcsp_pkg::bcsp_is_ext_mode(op_mode);

    // ************************************************************
    // Pin and standby synchronisers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Pins idle high, so the active-low wait and request lines stay quiet after reset.
            pin_meta <= 8'hff;
            pin_sync <= 8'hff;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_meta <= 1'b0;
            standby_sync <= 1'b0;
        end else begin
            standby_meta <= hw_standby;
            standby_sync <= standby_meta;
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    // Zero wait states keep the slave simple; every access ends in its first access cycle.
    assign access = psel && penable;
    assign hit = (paddr == bcsp_pkg::BCSP_ADDR_DIRECTION) ||
                 (paddr == bcsp_pkg::BCSP_ADDR_PIN_LEVELS) ||
                 (paddr == bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH);
    assign wr_dir = access && pwrite && (paddr == bcsp_pkg::BCSP_ADDR_DIRECTION);
    assign wr_latch = access && pwrite && (paddr == bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH);
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    always_comb begin
        prdata = bcsp_pkg::BCSP_UNMAPPED_READ;
        if (access && !pwrite) begin
            if (paddr == bcsp_pkg::BCSP_ADDR_DIRECTION) begin
                // RQ1: direction is not readable
                prdata = {24'h000000, bcsp_pkg::BCSP_DIR_READ_VALUE};
            end else if (paddr == bcsp_pkg::BCSP_ADDR_PIN_LEVELS) begin
                // RQ11: latch for outputs, pin for inputs
                prdata = {24'h000000, (port_direction & port_output_latch) |
                                      (~port_direction & port_pin_levels)};
            end else if (paddr == bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH) begin
                prdata = {24'h000000, port_output_latch};
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // The async reset may only load a constant, so the mode-dependent
    // value is loaded at the first edge after release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_pending <= 1'b1;
        end else begin
            init_pending <= standby_sync;
        end
    end

    assign next_direction = ext_mode ? bcsp_pkg::BCSP_DIR_RST_EXT
                                     : bcsp_pkg::BCSP_DIR_RST_SINGLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction <= bcsp_pkg::BCSP_DIR_RST_SINGLE;
        end else if (init_pending || standby_sync) begin
            // RQ2: mode-dependent initial direction
            port_direction <= next_direction;
        end else if (wr_dir) begin
            // RQ1: write-only direction
            port_direction <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_latch <= bcsp_pkg::BCSP_LATCH_RST;
        end else if (standby_sync) begin
            // RQ9: hardware standby clears latch
            port_output_latch <= bcsp_pkg::BCSP_LATCH_RST;
        end else if (wr_latch) begin
            // RQ10: outputs set through latch only
            port_output_latch <= pwdata[7:0];
        end
    end

    // RQ3: pin view frozen in standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_levels <= 8'h00;
        end else if (!soft_standby) begin
            port_pin_levels <= pin_sync;
        end
    end

    // ************************************************************
    // Standby output hold
    // ************************************************************
    assign live_strobes_n = {address_strobe_n, read_strobe_n,
                             upper_byte_write_n, lower_byte_write_n};

    // RQ4: capture levels on standby entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_strobes_n <= 4'hf;
            held_bus_ack_n <= 1'b1;
        end else if (!soft_standby) begin
            held_strobes_n <= live_strobes_n;
            held_bus_ack_n <= bus_ack_n;
        end
    end

    assign mux_strobes_n = soft_standby ? held_strobes_n : live_strobes_n;
    assign mux_bus_ack_n = soft_standby ? held_bus_ack_n : bus_ack_n;

    // ************************************************************
    // Pin drive
    // ************************************************************
    bcsp_pin_mux u_mux (
        .ext_mode(ext_mode),
        .direction(port_direction),
        .latch(port_output_latch),
        .sys_clock_level(sys_clock_level),
        .strobes_n(mux_strobes_n),
        .bus_ack_n(mux_bus_ack_n),
        .stall_en(stall_input_enable),
        .release_en(bus_release_enable),
        .standby(soft_standby),
        .hold(standby_output_hold),
        .next_out(next_pin_out),
        .next_oe(next_pin_oe)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // RQ7: wait and request to controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_n <= 1'b1;
            bus_request_n <= 1'b1;
        end else begin
            wait_n <= (ext_mode && stall_input_enable) ?
                      pin_sync[bcsp_pkg::BCSP_PIN_WAIT] : 1'b1;
            bus_request_n <= (ext_mode && bus_release_enable) ?
                             pin_sync[bcsp_pkg::BCSP_PIN_BUS_REQ] : 1'b1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // The edge at which reset is released still loads reset values, so checks that
    // look one edge ahead from there also require presetn in their antecedent.
    a_dir_init_value: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        presetn && init_pending |=> port_direction ==
            (ext_mode ? bcsp_pkg::BCSP_DIR_RST_EXT : bcsp_pkg::BCSP_DIR_RST_SINGLE))
        else $error("direction not loaded with mode reset value");

    a_dir_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        access && !pwrite && paddr == bcsp_pkg::BCSP_ADDR_DIRECTION
        |-> prdata == 32'h0000_0000)
        else $error("direction read returned stored value");

    a_latch_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        wr_latch && !standby_sync |=> port_output_latch == $past(pwdata[7:0]))
        else $error("output latch did not take write data");

    a_pin_view_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        access && !pwrite && paddr == bcsp_pkg::BCSP_ADDR_PIN_LEVELS
        |-> prdata[7:0] == ((port_direction & port_output_latch) |
                            (~port_direction & port_pin_levels)))
        else $error("pin view read mismatch");

    a_view_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        soft_standby ##1 soft_standby |-> $stable(port_pin_levels))
        else $error("pin view changed in standby");

    a_standby_float: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        ext_mode && soft_standby && !standby_output_hold
        |=> pin_oe[6:3] == 4'h0)
        else $error("bus strobes driven in standby without hold");

    a_clock_pin: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        port_direction[7] |=> pin_oe[7] && pin_out[7] == $past(sys_clock_level))
        else $error("clock pin not driving clock level");

    a_strobe_pins: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        presetn && ext_mode && !soft_standby
        |=> pin_oe[6:3] == 4'hf && pin_out[6:3] == $past(live_strobes_n))
        else $error("strobe pins not driven");

    a_request_path: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        presetn && $past(presetn) && ext_mode && bus_release_enable
        ##1 ext_mode && bus_release_enable
        |=> bus_request_n == $past(pin_in[0], 3))
        else $error("bus request not passed from pin");

    a_single_chip: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        !ext_mode |=> pin_oe[6:0] == $past(port_direction[6:0]) &&
                      pin_out[6:0] == $past(port_output_latch[6:0]))
        else $error("single-chip pin not general I/O");

    a_wait_input: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        ext_mode && stall_input_enable |=> !pin_oe[2])
        else $error("wait pin driven while stall enabled");

    a_bus_ack_pin: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        presetn && ext_mode && bus_release_enable && !soft_standby
        |=> pin_oe[1] && !pin_oe[0] && pin_out[1] == $past(bus_ack_n))
        else $error("bus release pins wrong");

    c_latch_write: cover property (@(posedge pclk) disable iff (!presetn) wr_latch);
    c_standby_hold: cover property (@(posedge pclk) disable iff (!presetn)
        ext_mode && soft_standby && standby_output_hold);
    c_bus_release: cover property (@(posedge pclk) disable iff (!presetn)
        ext_mode && bus_release_enable && !bus_request_n);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

// *** testbench/bcsp_pin_model.sv ***
// Pin-side model of the port: external drivers and the level that each pin resolves to.
`timescale 1ns/1ns
module bcsp_pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // ************************************************************
    // Pin resolution
    // ************************************************************
    // live pin level
    // A pin the port drives reads back its own level, so the pin view of a
    // latch-driven output pin can never be told apart from the latch by the pin alone.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule

// *** testbench/test_bus_control_shared_port.sv ***
// Self-checking bench of the bus control shared port.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module test_bus_control_shared_port;
    typedef struct packed {
        logic [2:0] mode;
        logic clk, st, rl;
        logic [7:0] dir, lat, ext, oe, out, view;
        logic wt, rq;
    } bcsp_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [19:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er;
    logic [2:0] op_mode = 3'h1;
    logic hw_standby = 0, soft_standby = 0, standby_output_hold = 1;
    logic stall_input_enable = 0, bus_release_enable = 0, sys_clock_level = 1;
    logic address_strobe_n = 0, read_strobe_n = 1, upper_byte_write_n = 0;
    logic lower_byte_write_n = 1, bus_ack_n = 0, wait_n, bus_request_n;
    logic [7:0] pin_in, pin_out, pin_oe, ext_level = 8'h00;
    int miscompares = 0, tests_run = 0;
    bcsp_row_t rows [7] = '{
        '{3'h3, 1'b1, 1'b1, 1'b1, 8'h0f, 8'ha5, 8'h3c, 8'h0f, 8'h05, 8'h35, 1'b1, 1'b1},
        '{3'h7, 1'b0, 1'b0, 1'b0, 8'hf0, 8'ha5, 8'h3c, 8'hf0, 8'h20, 8'hac, 1'b1, 1'b1},
        '{3'h1, 1'b1, 1'b0, 1'b0, 8'h87, 8'h02, 8'h3c, 8'hff, 8'haa, 8'h2a, 1'b1, 1'b1},
        '{3'h4, 1'b1, 1'b1, 1'b1, 8'h00, 8'hff, 8'h00, 8'h7a, 8'h28, 8'h28, 1'b0, 1'b0},
        '{3'h2, 1'b0, 1'b1, 1'b0, 8'h83, 8'h5a, 8'h3c, 8'hfb, 8'h2a, 8'h2e, 1'b1, 1'b1},
        '{3'h5, 1'b1, 1'b0, 1'b1, 8'h01, 8'h00, 8'h41, 8'h7a, 8'h28, 8'h28, 1'b1, 1'b1},
        '{3'h6, 1'b1, 1'b0, 1'b1, 8'h06, 8'h04, 8'h00, 8'h7e, 8'h2c, 8'h2c, 1'b1, 1'b0}
    };

    always #2 pclk = ~pclk;

    bcsp_port u_bcsp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .op_mode(op_mode), .hw_standby(hw_standby),
        .soft_standby(soft_standby), .standby_output_hold(standby_output_hold),
        .stall_input_enable(stall_input_enable), .bus_release_enable(bus_release_enable),
        .sys_clock_level(sys_clock_level), .address_strobe_n(address_strobe_n),
        .read_strobe_n(read_strobe_n), .upper_byte_write_n(upper_byte_write_n),
        .lower_byte_write_n(lower_byte_write_n), .bus_ack_n(bus_ack_n), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .wait_n(wait_n), .bus_request_n(bus_request_n));

    bcsp_pin_model u_bcsp_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .pin_in(pin_in));

    // ************************************************************
    // Bus and run control
    // ************************************************************
    // The request is held until pready is seen high with the access phase.
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        do_reset();
        `CHK(pin_oe, 8'hf8)
        `CHK(pin_out[7], 1'b1)
        apb(1'b0, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0);
        `CHK(rd[7:0], bcsp_pkg::BCSP_LATCH_RST)
        foreach (rows[k]) begin
            op_mode <= rows[k].mode;
            sys_clock_level <= rows[k].clk;
            stall_input_enable <= rows[k].st;
            bus_release_enable <= rows[k].rl;
            ext_level <= rows[k].ext;
            apb(1'b1, bcsp_pkg::BCSP_ADDR_DIRECTION, {24'h0, rows[k].dir});
            apb(1'b1, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, {24'h0, rows[k].lat});
            repeat (6) @(posedge pclk);
            `CHK(pin_oe, rows[k].oe)
            `CHK(pin_out & pin_oe, rows[k].out)
            `CHK({wait_n, bus_request_n}, {rows[k].wt, rows[k].rq})
            apb(1'b0, bcsp_pkg::BCSP_ADDR_PIN_LEVELS, 32'h0);
            `CHK(rd[7:0], rows[k].view)
            apb(1'b0, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0);
            `CHK(rd[7:0], rows[k].lat)
        end
        apb(1'b0, bcsp_pkg::BCSP_ADDR_DIRECTION, 32'h0);
        `CHK(rd[7:0], bcsp_pkg::BCSP_DIR_READ_VALUE)
        apb(1'b0, 20'h00010, 32'h0);
        `CHK({er, rd}, {1'b1, bcsp_pkg::BCSP_UNMAPPED_READ})
        apb(1'b1, bcsp_pkg::BCSP_ADDR_PIN_LEVELS, 32'h0000_00ff);
        `CHK(er, 1'b0)
        apb(1'b0, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0);
        `CHK(rd[7:0], 8'h04)
        apb(1'b1, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0000_005a);
        soft_standby <= 1'b1;
        repeat (3) @(posedge pclk);
        address_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK({pin_oe[6], pin_out[6]}, 2'b10)
        standby_output_hold <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(pin_oe[6:3], 4'h0)
        soft_standby <= 1'b0;
        address_strobe_n <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(pin_oe[6:3], 4'hf)
        apb(1'b0, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0);
        `CHK(rd[7:0], 8'h5a)
        // A hardware standby must reload direction for the mode and clear the latch.
        stall_input_enable <= 1'b0;
        bus_release_enable <= 1'b0;
        hw_standby <= 1'b1;
        repeat (6) @(posedge pclk);
        hw_standby <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK(pin_oe, 8'hf8)
        apb(1'b0, bcsp_pkg::BCSP_ADDR_OUTPUT_LATCH, 32'h0);
        `CHK(rd[7:0], 8'h00)
        op_mode <= 3'h3;
        do_reset();
        `CHK(pin_oe, 8'h00)
        report_and_stop();
    end
endmodule
